// ---- lem_pkg.sv ----
// Shared constants, types and register map of the evacuation and load mode controller
package lem_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned SEC_NS        = 1_000_000_000; // One second in ns
	localparam int unsigned CLK_PERIOD_NS = 50;            // pclk period in ns
	localparam int unsigned TICKS_PER_SEC = SEC_NS / CLK_PERIOD_NS; // Cycles per second

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CFG    = 8'h00; // Configuration
	localparam logic [7:0] OFS_DELAY  = 8'h04; // Evacuation delay in seconds
	localparam logic [7:0] OFS_STATUS = 8'h08; // Read-only status

	// ----------------------------------------------------------------
	// CFG field positions
	// ----------------------------------------------------------------
	localparam int CFG_CC_LSB      = 0;  // Call cancel code, 2 bits
	localparam int CFG_EVAC_EN     = 2;  // Evacuation enable
	localparam int CFG_POST_FREE   = 3;  // Free after evacuation
	localparam int CFG_HYDRAULIC   = 4;  // Hydraulic lift type
	localparam int CFG_SPEED_LSB   = 5;  // Evacuation speed, 3 bits
	localparam int CFG_LAND_LSB    = 8;  // Evacuation landing, 6 bits
	localparam int CFG_PARK2_LSB   = 14; // Parking landing in timed mode 2, 6 bits
	localparam int CFG_OVL_IND_EN  = 20; // Overload lamp configured
	localparam int CFG_BUZZER_EN   = 21; // Overload buzzer configured
	localparam int CFG_BATT_INV    = 22; // Inverter fed from batteries
	localparam logic [31:0] CFG_RST   = 32'h0000_0000; // CFG reset value
	localparam logic [31:0] CFG_MASK  = 32'h007F_FFFF; // Implemented CFG bits
	localparam logic [7:0]  DELAY_RST = 8'h0A;         // Delay reset value

	// ----------------------------------------------------------------
	// Landings and synchroniser map
	// ----------------------------------------------------------------
	localparam logic [5:0] LOWEST_LANDING = 6'h01; // Bottom landing number
	localparam int SY_TM1 = 0;  // Timed mode 1 contact
	localparam int SY_TM2 = 1;  // Timed mode 2 contact
	localparam int SY_EVAC = 2; // Evacuation request
	localparam int SY_EREL = 3; // Release from preceding lift
	localparam int SY_RAE = 4;  // Release after evacuation
	localparam int SY_CHG = 5;  // Change evacuation direction
	localparam int SY_FULL = 6; // Full load
	localparam int SY_OVL = 7;  // Overload
	localparam int SY_ZERO = 8; // Zero load
	localparam int SY_HALF = 9; // Below half load
	localparam int SY_DFAIL = 10; // Drive failure
	localparam int NSYNC = 11;  // Number of synchronised contacts

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		EV_IDLE = 3'b000, EV_STOP = 3'b001, EV_WAIT = 3'b010,
		EV_TRAVEL = 3'b011, EV_HOLD = 3'b100, EV_DONE = 3'b101
	} lem_evac_e;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00, MODE_TM1 = 2'b01, MODE_TM2 = 2'b10
	} lem_mode_e;

	typedef enum logic [2:0] {
		relevel_speed = 3'b000, approach_speed = 3'b001, first_intermediate_speed = 3'b010,
		second_intermediate_speed = 3'b011, rated_speed = 3'b100
	} lem_speed_e;

	// Car status reported by the motion controller
	typedef struct packed {
		logic       moving;     // Car travelling
		logic       at_landing; // Car level at a landing
		logic [5:0] landing;    // Current or last landing
		logic       failed;     // Lift failed or out of service
		logic [5:0] car_calls;  // Number of pending car calls
	} lem_car_s;

	// Evacuation travel commands
	typedef struct packed {
		logic       go;        // Travel to target
		logic       stop_next; // Stop at next possible landing
		logic       door_open; // Open and hold doors
		logic [5:0] target;    // Target landing
		logic       dir_up;    // Travel direction
		lem_speed_e speed;     // Travel speed
	} lem_evcmd_s;

endpackage

// ---- lem_ctrl.sv ----
// Evacuation, timed mode and load mode decision logic with APB configuration
//
// Notes on behaviour
// - Two-bit code picks timed-mode call clearing
// - Timed mode 2 wins over mode 1
// - Mode 2 selects own doors and parking
// - Evacuation enable 0 disables all evacuation
// - Standstill off landing starts evacuation delay
// - Moving away: stop next, open, start delay
// - Delay expiry or forerunner release starts travel
// - Hydraulic lifts go lowest without delay
// - Post setting: hold open or resume service
// - Landing 0 means next landing, else fixed
// - Landing 0: battery inverter drive failure goes lower
// - Follower contact closed in normal/incomplete evacuation
// - At landing or failed opens contact
// - Indicator on throughout evacuation
// - Release input at landing resumes normal
// - Three-bit setting selects evacuation speed
// - Change input reverses evacuation direction
// - Full load: car calls only, leave group
// - Overload standstill: hold open, lamp, buzzer
// - Overload ignored while travelling
// - Zero load cancels calls beyond one
// - Landing 0: half load chooses up/down
`timescale 1ns/1ns
`default_nettype none

module lem_ctrl
	import lem_pkg::*;
#(
	parameter int unsigned TICKS_SEC = TICKS_PER_SEC // Cycles per second of delay
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Contacts
	input  wire logic [NSYNC-1:0]  contacts,
	// Car status
	input  wire lem_car_s          car,
	// Timed mode outputs
	output var  lem_mode_e         mode,
	output logic                   tm2_door_tables,
	output logic                   park_override,
	output logic [5:0]             park_landing,
	output logic                   clear_all_calls,
	// Load outputs
	output logic                   landing_assign_off,
	output logic                   car_calls_only,
	output logic                   leave_group,
	output logic                   overload_hold,
	output logic                   overload_lamp,
	output logic                   overload_buzzer,
	output logic                   clear_car_calls,
	// Evacuation outputs
	output var  lem_evcmd_s        evac_cmd,
	output logic                   evac_active,
	output logic                   evac_end_perm
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NSYNC-1:0] s1;        // Synchroniser first stage
		logic [NSYNC-1:0] s2;        // Synchroniser second stage
		lem_evac_e        st;        // Evacuation state
		logic [7:0]       dly;       // Remaining delay in seconds
		logic [31:0]      pre;       // Second prescaler
		logic             flip;      // Direction reversed
		logic             chg_d;     // Change input last cycle
		lem_mode_e        mode;      // Timed operating mode
		logic             clr_all;   // Timed mode call clear pulse
		logic             clr_car;   // Zero load car call clear
		logic [5:0]       target;    // Evacuation target landing
		logic             dir_up;    // Base travel direction
		logic [31:0]      cfg;       // Configuration register
		logic [7:0]       dly_cfg;   // Delay setting in seconds
		logic [31:0]      rdata;     // Read data holding register
	} lem_state_s;

	lem_state_s r_r;   // Registered state
	lem_state_s r_nxt; // Next state

	// Configuration fields
	logic [1:0] cc;        // Call cancel code
	logic       evac_en;   // Evacuation enabled
	logic       post_free; // Resume after evacuation
	logic       hydraulic; // Hydraulic type
	logic [5:0] evac_land; // Evacuation landing setting
	logic       evac_on;   // Evacuation requested and enabled
	logic       at_evac;   // Standing at the evacuation landing
	logic       travel;    // In the evacuation travel state

	assign cc        = r_r.cfg[CFG_CC_LSB +: 2];
	assign evac_en   = r_r.cfg[CFG_EVAC_EN];
	assign post_free = r_r.cfg[CFG_POST_FREE];
	assign hydraulic = r_r.cfg[CFG_HYDRAULIC];
	assign evac_land = r_r.cfg[CFG_LAND_LSB +: 6];
	assign evac_on   = evac_en & r_r.s2[SY_EVAC];

	// Already at the landing: fixed landing matched, or any landing for setting 0
	assign at_evac = ~car.moving & car.at_landing &
		((evac_land == 6'h00) | (car.landing == evac_land));
	assign travel  = (r_r.st == EV_TRAVEL);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		lem_mode_e  mode_nxt;
		logic [5:0] tgt;
		logic       hit;
		r_nxt = r_r;
		mode_nxt = MODE_NORMAL;
		tgt = 6'h00;
		hit = 1'b0;

		// Two-flop synchronisers; only stage two is used
		r_nxt.s1 = contacts;
		r_nxt.s2 = r_r.s1;

		// Timed mode selection, mode 2 first
		if (r_r.s2[SY_TM2]) begin
			mode_nxt = MODE_TM2;
		end else if (r_r.s2[SY_TM1]) begin
			mode_nxt = MODE_TM1;
		end
		r_nxt.mode = mode_nxt;

		// Clear all calls on entry (codes 2, 3) or exit (codes 1, 3)
		r_nxt.clr_all = ((r_r.mode == MODE_NORMAL) & (mode_nxt != MODE_NORMAL) & cc[1]) |
			((r_r.mode != MODE_NORMAL) & (mode_nxt == MODE_NORMAL) & cc[0]);

		// Zero load keeps at most one car call
		r_nxt.clr_car = r_r.s2[SY_ZERO] & (car.car_calls > 6'd1);

		// Target for setting 0: half load and drive failure pick the side
		if (evac_land != 6'h00) begin
			tgt = evac_land;
		end else if (r_r.s2[SY_DFAIL] & r_r.cfg[CFG_BATT_INV]) begin
			tgt = car.landing - 6'd1;
		end else if (r_r.s2[SY_HALF]) begin
			tgt = car.landing + 6'd1;
		end else begin
			tgt = car.landing - 6'd1;
		end

		// Direction change edge during evacuation travel
		r_nxt.chg_d = r_r.s2[SY_CHG];
		if (travel & r_r.s2[SY_CHG] & ~r_r.chg_d) begin
			r_nxt.flip = ~r_r.flip;
			if (evac_land == 6'h00) begin
				r_nxt.target = (r_r.dir_up ^ r_r.flip) ? car.landing - 6'd1 :
					car.landing + 6'd1;
			end
		end

		// Evacuation sequence
		unique case (r_r.st)
			EV_IDLE: begin
				r_nxt.flip = 1'b0;
				r_nxt.pre = 32'h0000_0000;
				if (evac_on) begin
					if (hydraulic) begin
						r_nxt.target = LOWEST_LANDING;
						r_nxt.dir_up = 1'b0;
						r_nxt.st = EV_TRAVEL;
					end else if (at_evac) begin
						r_nxt.st = EV_HOLD;
					end else if (car.moving) begin
						r_nxt.st = EV_STOP;
					end else begin
						r_nxt.target = tgt;
						r_nxt.dir_up = (tgt > car.landing);
						r_nxt.dly = r_r.dly_cfg;
						r_nxt.st = EV_WAIT;
					end
				end
			end
			EV_STOP: begin
				// Stop at the next landing, then wait with doors open
				if (~evac_on) begin
					r_nxt.st = EV_IDLE;
				end else if (~car.moving & car.at_landing) begin
					r_nxt.target = tgt;
					r_nxt.dir_up = (tgt > car.landing);
					r_nxt.dly = r_r.dly_cfg;
					r_nxt.st = EV_WAIT;
				end
			end
			EV_WAIT: begin
				// Count seconds down; forerunner release cuts it short
				if (r_r.pre >= TICKS_SEC - 1) begin
					r_nxt.pre = 32'h0000_0000;
					if (r_r.dly != 8'h00) begin
						r_nxt.dly = r_r.dly - 8'd1;
					end
				end else begin
					r_nxt.pre = r_r.pre + 32'd1;
				end
				if (~evac_on) begin
					r_nxt.st = EV_IDLE;
				end else if ((r_r.dly == 8'h00) | r_r.s2[SY_EREL]) begin
					r_nxt.st = EV_TRAVEL;
				end
			end
			EV_TRAVEL: begin
				if (~evac_on) begin
					r_nxt.st = EV_IDLE;
				end else if (~car.moving & car.at_landing & (car.landing == r_r.target)) begin
					r_nxt.st = EV_HOLD;
				end
			end
			EV_HOLD: begin
				// Hold open until request drops, or resume service
				if (~evac_on) begin
					r_nxt.st = EV_IDLE;
				end else if (post_free | r_r.s2[SY_RAE]) begin
					r_nxt.st = EV_DONE;
				end
			end
			EV_DONE: begin
				if (~evac_on) begin
					r_nxt.st = EV_IDLE;
				end
			end
			default: begin
				r_nxt.st = EV_IDLE;
			end
		endcase

		// APB: capture read data in setup, write in access
		unique case (paddr)
			OFS_CFG, OFS_DELAY, OFS_STATUS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		if (psel & ~penable) begin
			unique case (paddr)
				OFS_CFG:    r_nxt.rdata = r_r.cfg;
				OFS_DELAY:  r_nxt.rdata = {24'h00_0000, r_r.dly_cfg};
				OFS_STATUS: r_nxt.rdata = {16'h0000, r_r.dly, 1'b0, evac_end_perm,
					evac_active, r_r.mode, r_r.st};
				default:    r_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (psel & penable & pwrite & hit) begin
			if (paddr == OFS_CFG) begin
				r_nxt.cfg = pwdata & CFG_MASK;
			end else if (paddr == OFS_DELAY) begin
				r_nxt.dly_cfg = pwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_r <= '0;
			r_r.cfg <= CFG_RST;
			r_r.dly_cfg <= DELAY_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata  = r_r.rdata;
	assign pready  = psel & penable;
	assign pslverr = psel & penable & ~((paddr == OFS_CFG) | (paddr == OFS_DELAY) |
		(paddr == OFS_STATUS));

	// Timed modes
	assign mode            = r_r.mode;
	assign tm2_door_tables = (r_r.mode == MODE_TM2);
	assign park_override   = (r_r.mode == MODE_TM2);
	assign park_landing    = r_r.cfg[CFG_PARK2_LSB +: 6];
	assign clear_all_calls = r_r.clr_all;

	// Load handling; overload only counts at standstill
	assign overload_hold      = r_r.s2[SY_OVL] & ~car.moving;
	assign overload_lamp      = overload_hold & r_r.cfg[CFG_OVL_IND_EN];
	assign overload_buzzer    = overload_hold & r_r.cfg[CFG_BUZZER_EN];
	assign landing_assign_off = r_r.s2[SY_FULL] | overload_hold;
	assign car_calls_only     = r_r.s2[SY_FULL];
	assign leave_group        = r_r.s2[SY_FULL] | overload_hold;
	assign clear_car_calls    = r_r.clr_car;

	// Evacuation commands
	assign evac_cmd.go        = travel;
	assign evac_cmd.stop_next = (r_r.st == EV_STOP);
	assign evac_cmd.door_open = (r_r.st == EV_WAIT) | (r_r.st == EV_HOLD) | overload_hold;
	assign evac_cmd.target    = r_r.target;
	assign evac_cmd.dir_up    = r_r.dir_up ^ r_r.flip;
	assign evac_cmd.speed     = lem_speed_e'(r_r.cfg[CFG_SPEED_LSB +: 3]);
	assign evac_active        = evac_on;

	// Contact open grants the follower; closed otherwise
	assign evac_end_perm = car.failed | (evac_on & ((r_r.st == EV_HOLD) |
		(r_r.st == EV_DONE) | ((r_r.st == EV_IDLE) & at_evac)));

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_tm2_wins: assert property (r_r.s2[SY_TM1] && r_r.s2[SY_TM2] |=> mode == MODE_TM2 && park_override)
		else $error("timed mode 2 did not win");
	a_cancel_entry: assert property ($rose(r_r.mode != MODE_NORMAL) && cc[1] |-> clear_all_calls)
		else $error("no call clear on timed mode entry");
	a_evac_disabled: assert property (!evac_en |=> r_r.st == EV_IDLE)
		else $error("evacuation active while disabled");
	a_hyd_direct: assert property (r_r.st == EV_IDLE && evac_on && hydraulic
		|=> r_r.st == EV_TRAVEL && r_r.target == LOWEST_LANDING)
		else $error("hydraulic lift did not go straight down");
	a_release_go: assert property (r_r.st == EV_WAIT && evac_on && r_r.s2[SY_EREL]
		|=> evac_cmd.go)
		else $error("forerunner release did not start travel");
	a_perm_closed: assert property (!evac_on && !car.failed |-> !evac_end_perm)
		else $error("follower granted in normal operation");
	a_fail_perm: assert property (car.failed |-> evac_end_perm)
		else $error("failed lift kept follower contact closed");
	a_evac_lamp: assert property (r_r.st != EV_IDLE && evac_en |-> evac_active || $fell(evac_on))
		else $error("evacuation indicator dropped");
	a_ovl_travel: assert property (car.moving |-> !overload_lamp && !overload_hold)
		else $error("overload acted during travel");
	a_zero_load: assert property (r_r.s2[SY_ZERO] && car.car_calls > 6'd1 |=> clear_car_calls)
		else $error("zero load left several car calls");
	a_full_load: assert property (r_r.s2[SY_FULL] |-> car_calls_only && leave_group
		&& landing_assign_off)
		else $error("full load not honoured");

	c_evac_hold: cover property (r_r.st == EV_TRAVEL ##1 r_r.st == EV_HOLD);
	c_delay_exp: cover property (r_r.st == EV_WAIT && r_r.dly == 8'h00 ##1 r_r.st == EV_TRAVEL);
	c_tm2_entry: cover property ($rose(r_r.mode == MODE_TM2));
	c_overload: cover property (overload_hold && overload_buzzer);

endmodule
`default_nettype wire

// ---- lem_far_model.sv ----
// Far-side model: emergency supply, forerunner lift and car motion
`timescale 1ns/1ns
`default_nettype none

module lem_far_model
	import lem_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Bench control
	input  wire logic       power_lost,
	input  wire logic       lead_done,
	input  wire logic       slow,
	input  wire logic       hold_car,
	input  wire lem_car_s   car_init,
	// Controller side
	input  wire lem_evcmd_s evac_cmd,
	output logic            evac_req,
	output logic            lead_rel,
	output lem_car_s        car
);
	// ----------------------------------------------------------------
	// Supply and forerunner contacts
	// ----------------------------------------------------------------
	logic [1:0] gap_r; // Travel pacing, one landing per four cycles when slow

	// Supply relay closes while mains is lost
	assign evac_req = power_lost;
	// Forerunner opens its end contact once it sits at its landing
	assign lead_rel = lead_done;

	// ----------------------------------------------------------------
	// Car motion
	// ----------------------------------------------------------------
	// Bench may pin the car; otherwise it follows travel commands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			car <= '0;
			gap_r <= 2'h0;
		end else if (hold_car) begin
			car <= car_init;
		end else if (evac_cmd.go && car.landing != evac_cmd.target) begin
			car.moving <= 1'b1;
			car.at_landing <= 1'b0;
			gap_r <= gap_r + 2'h1;
			// Step one landing towards the target
			if (!slow || gap_r == 2'h3) begin
				car.landing <= (car.landing < evac_cmd.target) ? car.landing + 6'h01
					: car.landing - 6'h01;
			end
		end else begin
			// No travel command or target reached: car stands level
			car.moving <= 1'b0;
			car.at_landing <= 1'b1;
		end
	end
endmodule

`default_nettype wire

// ---- test_lift_evacuation_load_mode_ctrl.sv ----
// Self-checking bench for the evacuation and load mode controller
`timescale 1ns/1ns
`default_nettype none

module test_lift_evacuation_load_mode_ctrl
	import lem_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic              lost, lead, slow, hold, err, req, rel;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [10:0]       ctc;
	logic [NSYNC-1:0]  contacts;
	lem_car_s          car, car0;
	lem_mode_e         mode;
	lem_evcmd_s        ev;
	logic [5:0]        park;
	logic              tm2d, pko, cac, lao, cco, lvg, ovh, ovl, ovb, ccc, eva, perm;
	logic [16:0]       rnd;
	int                fail_count, n_checks, pulses, n;

	// Supply and forerunner contacts come from the far-side model
	assign contacts = {ctc[10:4], rel, req, ctc[1:0]};

	lem_ctrl #(.TICKS_SEC(4)) lem_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .contacts(contacts),
		.car(car), .mode(mode), .tm2_door_tables(tm2d), .park_override(pko),
		.park_landing(park), .clear_all_calls(cac), .landing_assign_off(lao),
		.car_calls_only(cco), .leave_group(lvg), .overload_hold(ovh),
		.overload_lamp(ovl), .overload_buzzer(ovb), .clear_car_calls(ccc),
		.evac_cmd(ev), .evac_active(eva), .evac_end_perm(perm));

	lem_far_model lem_far_model_i (.pclk(pclk), .presetn(presetn), .power_lost(lost),
		.lead_done(lead), .slow(slow), .hold_car(hold), .car_init(car0),
		.evac_cmd(ev), .evac_req(req), .lead_rel(rel), .car(car));

	// ----------------------------------------------------------------
	// Clock, pulse counter, watchdog
	// ----------------------------------------------------------------
	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	// Counts call-clearing pulses
	always @(posedge pclk) if (cac === 1'b1) pulses = pulses + 1;

	// Cuts a hang short
	initial begin
		repeat (30000) @(posedge pclk);
		fail_count++;
		print_verdict;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [16:0] lfsr(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction

	function automatic logic [31:0] bitv(input int p);
		return 32'h0000_0001 << p;
	endfunction

	// Compares one result
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; read data and error taken at the pready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Settled sampling point
	task cyc(input int c);
		repeat (c) @(negedge pclk);
	endtask

	task con(input int b, input logic v);
		@(posedge pclk);
		ctc[b] <= v;
	endtask

	task setcar(input logic mv, at, input logic [5:0] ld, input logic f, input logic [5:0] cc);
		@(posedge pclk);
		car0 <= '{mv, at, ld, f, cc};
		hold <= 1'b1;
	endtask

	task supply(input logic v, input logic ld, input logic hd);
		@(posedge pclk);
		lost <= v;
		lead <= ld;
		hold <= hd;
	endtask

	// Bounded wait on travel command (0) or follower permission (1)
	task wsig(input int k);
		n = 0;
		while ((k == 0 ? ev.go : perm) !== 1'b1 && n < 60) begin
			@(negedge pclk);
			n++;
		end
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, lost, lead, slow} = '0;
		{paddr, pwdata, ctc} = '0;
		hold = 1'b1;
		car0 = '0;
		rnd = 17'h1_435F;
		{fail_count, n_checks, pulses} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// Register reset values, access and unmapped place
		apb(1'b0, OFS_CFG, 32'h0000_0000);
		chk("cfg reset", CFG_RST, rd);
		apb(1'b0, OFS_DELAY, 32'h0000_0000);
		chk("delay reset", {24'h00_0000, DELAY_RST}, rd);
		apb(1'b1, OFS_CFG, 32'hFFFF_FFFF);
		apb(1'b0, OFS_CFG, 32'h0000_0000);
		chk("cfg mask", CFG_MASK, rd);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk("unmapped", 32'h0000_0001, {31'h0, err});
		// Call clearing codes around timed mode 1
		for (int cc = 0; cc < 4; cc++) begin
			apb(1'b1, OFS_CFG, 32'(cc));
			pulses = 0;
			con(SY_TM1, 1'b1);
			cyc(6);
			chk("clear at start", 32'(cc[1]), pulses);
			pulses = 0;
			con(SY_TM1, 1'b0);
			cyc(6);
			chk("clear at end", 32'(cc[0]), pulses);
		end
		// Both timed modes, parking landing 7
		apb(1'b1, OFS_CFG, 32'h0001_C000);
		con(SY_TM1, 1'b1);
		con(SY_TM2, 1'b1);
		cyc(6);
		chk("mode", MODE_TM2, mode);
		chk("doors", 3, {pko, tm2d});
		chk("park", 7, park);
		con(SY_TM1, 1'b0);
		con(SY_TM2, 1'b0);
		// Evacuation switched off
		apb(1'b1, OFS_CFG, 32'h0000_0100);
		setcar(1'b0, 1'b1, 6'h05, 1'b0, 6'h00);
		supply(1'b1, 1'b0, 1'b0);
		cyc(6);
		chk("disabled", 0, {eva, perm, ev.door_open});
		supply(1'b0, 1'b0, 1'b1);
		// Sequential evacuation, every speed code, delay or forerunner
		for (int s = 0; s < 5; s++) begin
			rnd = lfsr(rnd);
			setcar(1'b0, 1'b1, 6'h02 + {3'h0, rnd[2:0]}, 1'b0, 6'h00);
			apb(1'b1, OFS_DELAY, s[0] ? 32'h0000_0001 : 32'h0000_00C8);
			apb(1'b1, OFS_CFG, bitv(CFG_EVAC_EN) | (s[0] ? bitv(CFG_POST_FREE) : 32'h0)
				| (32'(s) << CFG_SPEED_LSB) | 32'h0000_0100);
			slow <= s[1];
			supply(1'b1, ~s[0], 1'b0);
			// Look in the first waiting cycle: a forerunner release ends it at once
			cyc(4);
			chk("active", 1, eva);
			chk("waiting", 1, ev.door_open);
			chk("perm closed", 0, perm);
			if (s[0]) chk("early go", 0, ev.go);
			wsig(0);
			chk("go", 1, ev.go);
			chk("target", 1, ev.target);
			chk("speed", 32'(s), ev.speed);
			wsig(1);
			chk("perm open", 1, perm);
			chk("active hold", 1, eva);
			if (!s[0]) begin
				chk("held open", 1, ev.door_open);
				con(SY_RAE, 1'b1);
				cyc(5);
				con(SY_RAE, 1'b0);
			end
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			chk("done", EV_DONE, rd[2:0]);
			supply(1'b0, 1'b0, 1'b1);
			cyc(6);
			chk("normal", 0, {eva, perm});
		end
		// Hydraulic lift ignores the long delay
		apb(1'b1, OFS_CFG, bitv(CFG_EVAC_EN) | bitv(CFG_HYDRAULIC) | 32'h0000_0300);
		supply(1'b1, 1'b0, 1'b1);
		cyc(5);
		chk("hyd go", 1, ev.go);
		chk("hyd target", LOWEST_LANDING, ev.target);
		supply(1'b0, 1'b0, 1'b1);
		// At landing, failed, or moving away
		apb(1'b1, OFS_CFG, bitv(CFG_EVAC_EN) | 32'h0000_0100);
		for (int i = 0; i < 3; i++) begin
			setcar(i == 2, i != 2, (i == 0) ? 6'h01 : 6'h05, i == 1, 6'h00);
			supply(1'b1, 1'b0, 1'b1);
			cyc(5);
			if (i < 2) chk("perm given", 1, perm);
			else chk("stop next", 1, ev.stop_next);
			supply(1'b0, 1'b0, 1'b1);
		end
		// Landing setting 0 between landings: load and drive failure pick way
		apb(1'b1, OFS_DELAY, 32'h0000_0000);
		apb(1'b1, OFS_CFG, bitv(CFG_EVAC_EN) | bitv(CFG_BATT_INV));
		for (int i = 0; i < 3; i++) begin
			setcar(1'b0, 1'b0, 6'h04, 1'b0, 6'h00);
			con(SY_HALF, i != 1);
			con(SY_DFAIL, i == 2);
			// Car stays pinned between landings, else it counts as arrived
			supply(1'b1, 1'b0, 1'b1);
			wsig(0);
			chk("direction", 32'(i == 0), ev.dir_up);
			if (i == 0) begin
				con(SY_CHG, 1'b1);
				cyc(4);
				chk("reversed", 0, ev.dir_up);
				chk("new target", 3, ev.target);
				con(SY_CHG, 1'b0);
			end
			supply(1'b0, 1'b0, 1'b1);
			cyc(3);
		end
		// Load contacts
		apb(1'b1, OFS_CFG, 32'h0030_0000);
		setcar(1'b0, 1'b1, 6'h03, 1'b0, 6'h02);
		con(SY_FULL, 1'b1);
		cyc(5);
		chk("full", 7, {cco, lao, lvg});
		con(SY_FULL, 1'b0);
		con(SY_OVL, 1'b1);
		cyc(5);
		chk("overload", 15, {ovh, ovl, ovb, lvg});
		setcar(1'b1, 1'b0, 6'h03, 1'b0, 6'h02);
		cyc(3);
		chk("ovl moving", 0, ovh);
		con(SY_OVL, 1'b0);
		con(SY_ZERO, 1'b1);
		setcar(1'b0, 1'b1, 6'h03, 1'b0, 6'h02);
		cyc(5);
		chk("zero two", 1, ccc);
		setcar(1'b0, 1'b1, 6'h03, 1'b0, 6'h01);
		cyc(3);
		chk("zero one", 0, ccc);
		print_verdict;
	end
endmodule

`default_nettype wire
